// ---- tec_pin_model.sv ----
/*
  Model of the external timer input pins.
  Assumes the bench calls its tasks; levels change just after an edge.
*/
`timescale 1ns/1ps
module tec_pin_model
(
  input wire logic clock, // Peripheral clock
  output logic pinFirst, // First timer input
  output logic pinSecond // Second timer input
);
  initial
  begin
    pinFirst = 1'b0;
    pinSecond = 1'b0;
  end
  task automatic drive(input bit second, input logic lvl);
    @(posedge clock);
    if (second)
      pinSecond <= lvl;
    else
      pinFirst <= lvl;
  endtask
  // A high pulse of the given clock count; below two it must be ignored.
  task automatic pulse(input bit second, input int width);
    drive(second, 1'b1);
    repeat (width - 1) @(posedge clock);
    drive(second, 1'b0);
  endtask
endmodule

// ---- tec_pkg.sv ----
/*
  Package for the 16-bit timer/event counter: register indices and byte
  addresses, field positions, reset values, mode codes and carrier structs.
  Assumes an APB slave with a 20-bit byte address and 32-bit data.
*/
package tec_pkg;

  // ==========================================================================
  // Register map (index; byte address is four times the index)
  // ==========================================================================
  localparam logic [15:0] IDX_COUNT = 16'hff12;
  localparam logic [15:0] IDX_CCFIRST = 16'hff14;
  localparam logic [15:0] IDX_CCSECOND = 16'hff16;
  localparam logic [15:0] IDX_MODECTL = 16'hff60;
  localparam logic [15:0] IDX_CCCTL = 16'hff61;
  localparam logic [15:0] IDX_PRESC = 16'hff62;
  localparam logic [15:0] IDX_OUTCTL = 16'hff63;
  localparam logic [19:0] ADDR_COUNT = {2'b00, IDX_COUNT, 2'b00};
  localparam logic [19:0] ADDR_CCFIRST = {2'b00, IDX_CCFIRST, 2'b00};
  localparam logic [19:0] ADDR_CCSECOND = {2'b00, IDX_CCSECOND, 2'b00};
  localparam logic [19:0] ADDR_MODECTL = {2'b00, IDX_MODECTL, 2'b00};
  localparam logic [19:0] ADDR_CCCTL = {2'b00, IDX_CCCTL, 2'b00};
  localparam logic [19:0] ADDR_PRESC = {2'b00, IDX_PRESC, 2'b00};
  localparam logic [19:0] ADDR_OUTCTL = {2'b00, IDX_OUTCTL, 2'b00};

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int MC_OVF = 0;
  localparam int MC_SEL_LO = 2;
  localparam int MC_SEL_HI = 3;
  localparam int CC_MODE_FIRST = 0;
  localparam int CC_SOURCE = 1;
  localparam int CC_MODE_SECOND = 2;
  localparam int PR_CLK_LSB = 0;
  localparam int PR_EDGE_FIRST_LSB = 4;
  localparam int PR_EDGE_SECOND_LSB = 6;
  localparam int OC_ENABLE = 0;
  localparam int OC_INV_FIRST = 1;
  localparam int OC_INV_SECOND = 2;
  localparam int OC_ONESHOT_MODE = 4;
  localparam int OC_ONESHOT_TRIG = 6;

  // ==========================================================================
  // Reset values and codes
  // ==========================================================================
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] RST_CC = 16'h0000;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  localparam logic [1:0] OPM_STOP = 2'b00;
  localparam logic [1:0] OPM_CLR_EDGE = 2'b01;
  localparam logic [1:0] OPM_FREE = 2'b10;
  localparam logic [1:0] OPM_CLR_MATCH = 2'b11;

  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;

  localparam logic [1:0] CLK_DIV1 = 2'b00;
  localparam logic [1:0] CLK_DIV4 = 2'b01;
  localparam logic [1:0] CLK_DIV16 = 2'b10;
  localparam logic [1:0] CLK_EVENT = 2'b11;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam logic [3:0] DIV16_LAST = 4'hf;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    TEC_OS_IDLE = 2'b01,
    TEC_OS_RUN = 2'b10
  } tec_oneshot_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } tec_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } tec_apb_rsp_s;

  typedef struct packed {
    tec_apb_rsp_s rsp;
    logic [2:0] syncFirst;
    logic [2:0] syncSecond;
    logic fltFirst;
    logic fltSecond;
    logic [3:0] div;
    logic [15:0] count;
    logic [15:0] ccFirst;
    logic [15:0] ccSecond;
    logic [7:0] modeCtl;
    logic [7:0] ccCtl;
    logic [7:0] presc;
    logic [7:0] outCtl;
    tec_oneshot_e oneshot;
    logic outLevel;
    logic outEnable;
    logic irqFirst;
    logic irqSecond;
  } tec_state_s;

endpackage

// ---- tec_props.sv ----
/*
  Checker for the timer/event counter, bound to its top module.
  Assumes the design answers each APB setup in the next cycle.
*/
`timescale 1ns/1ps
module tec_props
(
  input wire logic clock, // Peripheral clock
  input wire logic nrst, // Asynchronous reset, active low
  input tec_pkg::tec_apb_req_s apbReq, // APB request group
  input tec_pkg::tec_apb_rsp_s apbRsp, // APB response group
  input wire logic timerOutputPin, // Timer output level
  input wire logic timerOutputEnable, // Output driven flag
  input wire logic compareFirstIrq // First match request
);
  import tec_pkg::*;
  // ==================
  // Properties
  // ==================
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic setup;
  logic ccWr;
  assign setup = apbReq.psel && !apbReq.penable;
  assign ccWr = setup && apbReq.pwrite && apbReq.paddr == ADDR_CCFIRST;
  property p_readyNext; setup |=> apbRsp.pready; endproperty
  a_readyNext: assert property (p_readyNext)
    else $error("no answer after setup");
  property p_readyOne; apbRsp.pready |=> !apbRsp.pready; endproperty
  a_readyOne: assert property (p_readyOne)
    else $error("answer held too long");
  property p_cntWr;
    setup && apbReq.pwrite && apbReq.paddr == ADDR_COUNT |=> apbRsp.pslverr;
  endproperty
  a_cntWr: assert property (p_cntWr)
    else $error("counter write accepted");
  property p_cntRd;
    setup && !apbReq.pwrite && apbReq.paddr == ADDR_COUNT |=> !apbRsp.pslverr;
  endproperty
  a_cntRd: assert property (p_cntRd)
    else $error("counter read refused");
  property p_strbErr; ccWr && apbReq.pstrb[1:0] != 2'b11 |=> apbRsp.pslverr; endproperty
  a_strbErr: assert property (p_strbErr)
    else $error("partial compare write accepted");
  property p_strbOk; ccWr && apbReq.pstrb[1:0] == 2'b11 |=> !apbRsp.pslverr; endproperty
  a_strbOk: assert property (p_strbOk)
    else $error("full compare write refused");
  property p_irqPulse; compareFirstIrq |=> !compareFirstIrq; endproperty
  a_irqPulse: assert property (p_irqPulse)
    else $error("match request too close");
  property p_outGate;
    !timerOutputEnable && $past(!timerOutputEnable) |-> !timerOutputPin;
  endproperty
  a_outGate: assert property (p_outGate)
    else $error("output high while disabled");
  c_irq: cover property (compareFirstIrq);
  c_strb: cover property (ccWr && apbReq.pstrb[1:0] != 2'b11);
  c_out: cover property ($rose(timerOutputPin));
endmodule

bind tec_timer_event_counter tec_props props_u
(
  .clock(clock),
  .nrst(nrst),
  .apbReq(apbReq),
  .apbRsp(apbRsp),
  .timerOutputPin(timerOutputPin),
  .timerOutputEnable(timerOutputEnable),
  .compareFirstIrq(compareFirstIrq)
);

// ---- tec_tb.sv ----
/*
  Self-checking bench for the timer/event counter.
  Assumes the package, the design and the pin model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    samplesChecked++; \
    if ((g) !== (e)) \
    begin \
      numErrors++; \
      $display("Error t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module testbench;
  import tec_pkg::*;
  logic clock;
  logic nrst;
  tec_apb_req_s req;
  tec_apb_rsp_s rsp;
  logic pinFirst;
  logic pinSecond;
  logic outPin;
  logic outEn;
  logic irqFirst;
  logic irqSecond;
  logic [31:0] rd;
  logic err;
  logic [15:0] old;
  int numErrors = 0;
  int samplesChecked = 0;
  int c;
  tec_timer_event_counter dut_u
  (
    .clock(clock),
    .nrst(nrst),
    .apbReq(req),
    .apbRsp(rsp),
    .timerInputFirst(pinFirst),
    .timerInputSecond(pinSecond),
    .timerOutputPin(outPin),
    .timerOutputEnable(outEn),
    .compareFirstIrq(irqFirst),
    .compareSecondIrq(irqSecond)
  );
  tec_pin_model pins_u
  (
    .clock(clock),
    .pinFirst(pinFirst),
    .pinSecond(pinSecond)
  );
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ==================
  // Shared tasks
  // ==================
  task automatic summarize();
    $display("errors=%0d checks=%0d", numErrors, samplesChecked);
    if (numErrors == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [19:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clock);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    req.pstrb <= s;
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      numErrors++;
      summarize();
    end
    else
    begin
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask
  // Cycles between two first-match requests (0), output changes (1) or second-match requests (2).
  task automatic between(input int sel, output int cnt);
    int n;
    int hits;
    logic prev;
    n = 0;
    hits = 0;
    cnt = 0;
    prev = outPin;
    while (hits < 2 && n < 400)
    begin
      @(posedge clock);
      n++;
      cnt++;
      if (sel == 1 ? (outPin !== prev) : ((sel == 0 ? irqFirst : irqSecond) === 1'b1))
      begin
        hits++;
        if (hits == 1)
          cnt = 0;
      end
      prev = outPin;
    end
    if (n >= 400)
    begin
      numErrors++;
      summarize();
    end
  endtask
  // ==================
  // Scenarios
  // ==================
  task automatic scnRegs();
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(rd[15:0], RST_COUNT)
    apb(1'b1, ADDR_COUNT, 32'h1234, 4'hf);
    `CHK(err, 1'b1)
    apb(1'b1, ADDR_CCFIRST, 32'h00ab, 4'h1);
    `CHK(err, 1'b1)
    apb(1'b0, ADDR_CCFIRST, 32'h0, 4'hf);
    `CHK(rd[15:0], RST_CC)
    apb(1'b0, 20'h00010, 32'h0, 4'hf);
    `CHK(err, 1'b1)
  endtask
  task automatic scnInterval();
    apb(1'b1, ADDR_CCFIRST, 32'h4, 4'hf);
    apb(1'b1, ADDR_CCSECOND, 32'h2, 4'hf);
    apb(1'b1, ADDR_CCCTL, 32'h0, 4'hf);
    apb(1'b1, ADDR_OUTCTL, 32'h3, 4'hf);
    apb(1'b1, ADDR_MODECTL, {28'h0, OPM_CLR_MATCH, 2'b00}, 4'hf);
    between(1'b0, c);
    `CHK(c, 5)
    between(1'b1, c);
    `CHK(c, 5)
    `CHK(outEn, 1'b1)
    between(2, c);
    `CHK(c, 5)
  endtask
  task automatic scnRead();
    apb(1'b1, ADDR_CCCTL, 32'h4, 4'hf);
    apb(1'b1, ADDR_MODECTL, {28'h0, OPM_FREE, 2'b00}, 4'hf);
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    old = rd[15:0];
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(16'(rd[15:0] - old), 16'h0003)
    apb(1'b1, ADDR_MODECTL, 32'h0, 4'hf);
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(rd[15:0], RST_COUNT)
    apb(1'b1, ADDR_MODECTL, {28'h0, OPM_FREE, 2'b00}, 4'hf);
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(rd[15:0] != 16'h0, 1'b1)
    apb(1'b0, ADDR_CCSECOND, 32'h0, 4'hf);
    `CHK(rd[15:0], 16'h0002)
  endtask
  task automatic scnEdgeClear();
    apb(1'b1, ADDR_PRESC, 32'h10, 4'hf);
    apb(1'b1, ADDR_MODECTL, {28'h0, OPM_CLR_EDGE, 2'b00}, 4'hf);
    repeat (30) @(posedge clock);
    pins_u.drive(1'b0, 1'b1);
    repeat (6) @(posedge clock);
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(rd[15:0] < 16'd12, 1'b1)
    pins_u.drive(1'b0, 1'b0);
    // Event counting on rising first-pin edges; the one-clock pulse must be lost.
    apb(1'b1, ADDR_MODECTL, 32'h0, 4'hf);
    apb(1'b1, ADDR_PRESC, 32'h13, 4'hf);
    apb(1'b1, ADDR_MODECTL, {28'h0, OPM_FREE, 2'b00}, 4'hf);
    pins_u.pulse(1'b0, 1);
    repeat (4) @(posedge clock);
    pins_u.pulse(1'b0, 2);
    repeat (4) @(posedge clock);
    pins_u.pulse(1'b0, 3);
    repeat (6) @(posedge clock);
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(rd[15:0], 16'h0002)
  endtask
  task automatic scnCapture();
    logic [1:0] ctl [9] = '{3, 3, 3, 3, 2, 1, 1, 1, 1};
    logic [1:0] code [9] = '{1, 1, 0, 3, 1, 1, 0, 3, 3};
    logic lvl [9] = '{1, 0, 1, 0, 1, 1, 0, 1, 0};
    logic hit [9] = '{0, 1, 1, 0, 0, 1, 1, 1, 1};
    apb(1'b1, ADDR_MODECTL, {28'h0, OPM_FREE, 2'b00}, 4'hf);
    for (int i = 0; i < 11; i++)
    begin
      if (i < 9)
      begin
        apb(1'b1, ADDR_CCCTL, {30'h0, ctl[i]}, 4'hf);
        apb(1'b1, ADDR_PRESC, {24'h0, 8'(code[i]) << (ctl[i][1] ? 4 : 6)}, 4'hf);
      end
      apb(1'b0, ADDR_CCFIRST, 32'h0, 4'hf);
      old = rd[15:0];
      if (i < 9)
        pins_u.drive(!ctl[i][1], lvl[i]);
      else
        pins_u.pulse(1'b1, i - 8);
      repeat (6) @(posedge clock);
      apb(1'b0, ADDR_CCFIRST, 32'h0, 4'hf);
      if (i < 9)
        `CHK(rd[15:0] !== old, hit[i])
      else
        `CHK(rd[15:0] !== old, i == 10)
    end
  endtask
  task automatic scnOneShot();
    repeat (30) @(posedge clock);
    apb(1'b1, ADDR_OUTCTL, 32'h11, 4'hf);
    apb(1'b1, ADDR_OUTCTL, 32'h51, 4'hf);
    apb(1'b0, ADDR_COUNT, 32'h0, 4'hf);
    `CHK(rd[15:0] < 16'd12, 1'b1)
  endtask
  initial
  begin
    nrst = 1'b0;
    req = '0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    scnRegs();
    scnInterval();
    scnRead();
    scnEdgeClear();
    scnCapture();
    scnOneShot();
    summarize();
  end
endmodule

// ---- tec_timer_event_counter.sv ----
/*
  16-bit timer/event counter with two capture/compare registers, input
  edge selection, interval, square-wave, pulse and one-shot output.
  Assumes an APB master on the same clock and asynchronous input pins that
  are synchronised here.
*/
`timescale 1ns/1ps

// Function
// - Interval mode raises a periodic request every 1 to 65536 count clocks.
// - Input pulses count only if each level lasts two peripheral clocks.
// - Square-wave cycle is twice (programmed count plus one) times the count clock period.
// - Pulse mode gives programmable cycle and width, width below cycle.
// - One-shot mode emits a single pulse with software-set width.
// - Counter is read-only and increments once per count clock.
// - Reading the counter returns its instant value without losing counts.
// - Counter clears at reset and when both mode select bits are zero.
// - Edge clear-and-start mode clears the counter on each selected first-pin edge.
// - Match clear-and-start mode clears the counter on first-register match.
// - Writing the one-shot trigger clears the counter and starts a pulse.
// - Reading the counter never captures into the second register.
// - Control bit 0 selects capture or compare for the first register.
// - First register resets to zero and takes only full 16-bit writes.
// - In compare mode, equality with the counter raises the first request.
// - Source bit one captures from the first pin, zero from the second.
// - First-pin capture uses the opposite edge; code 11 captures nothing.
// - Second-pin capture uses the selected edge, both edges for code 11.
// - First-pin edge field at bits 5:4, second at bits 7:6.
// - Source bit at bit 1, capture/compare mode bit at bit 0.
// - Counting starts when mode select is nonzero and stops at 00.
module tec_timer_event_counter
(
  input wire logic clock, // 100 MHz peripheral clock
  input wire logic nrst, // Asynchronous reset, active low
  input tec_pkg::tec_apb_req_s apbReq, // APB request group
  output tec_pkg::tec_apb_rsp_s apbRsp, // APB response group
  input wire logic timerInputFirst, // First timer input pin
  input wire logic timerInputSecond, // Second timer input pin
  output logic timerOutputPin, // Timer output level
  output logic timerOutputEnable, // High while the output pin is driven
  output logic compareFirstIrq, // One-cycle request on first match
  output logic compareSecondIrq // One-cycle request on second match
);
  import tec_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic edgeHit(input logic [1:0] code, input logic rise,
                                   input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (code)
      EDGE_FALL: hit = fall;
      EDGE_RISE: hit = rise;
      EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [31:0] widen16(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  function automatic logic [31:0] widen8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction

  // ==========================================================================
  // State
  // ==========================================================================
  tec_state_s q;
  tec_state_s d;

  logic riseFirst;
  logic fallFirst;
  logic riseSecond;
  logic fallSecond;
  logic [1:0] opMode;
  logic running;
  logic presTick;
  logic countTick;
  logic edgeFirst;
  logic capTrigFirst;
  logic capTrigSecond;
  logic matchFirst;
  logic matchSecond;
  logic clearCount;
  logic wrapNow;
  logic setup;
  logic commit;
  logic doWrite;
  logic oneshotMode;
  logic oneshotTrig;
  logic pulseActive;
  logic fullWord16;

  always_comb
  begin
    d = q;

    // ========================================================================
    // Pin synchronisers and level filter
    // ========================================================================
    // A new level is accepted only once stages two and three agree, so a
    // level must stand for two clocks before it counts as an edge.
    d.syncFirst = {q.syncFirst[1:0], timerInputFirst};
    d.syncSecond = {q.syncSecond[1:0], timerInputSecond};
    if (q.syncFirst[1] == q.syncFirst[2])
    begin
      d.fltFirst = q.syncFirst[2];
    end
    if (q.syncSecond[1] == q.syncSecond[2])
    begin
      d.fltSecond = q.syncSecond[2];
    end
    riseFirst = d.fltFirst & ~q.fltFirst;
    fallFirst = ~d.fltFirst & q.fltFirst;
    riseSecond = d.fltSecond & ~q.fltSecond;
    fallSecond = ~d.fltSecond & q.fltSecond;

    // ========================================================================
    // Edge decoding
    // ========================================================================
    edgeFirst = edgeHit(q.presc[PR_EDGE_FIRST_LSB +: 2], riseFirst, fallFirst);
    // The first pin captures on the edge opposite to its valid edge.
    unique case (q.presc[PR_EDGE_FIRST_LSB +: 2])
      EDGE_RISE: capTrigFirst = fallFirst;
      EDGE_FALL: capTrigFirst = riseFirst;
      default: capTrigFirst = 1'b0;
    endcase
    capTrigSecond = edgeHit(q.presc[PR_EDGE_SECOND_LSB +: 2], riseSecond,
                            fallSecond);

    // ========================================================================
    // Count clock
    // ========================================================================
    opMode = {q.modeCtl[MC_SEL_HI], q.modeCtl[MC_SEL_LO]};
    running = (opMode != OPM_STOP);
    d.div = running ? q.div + 4'h1 : 4'h0;
    unique case (q.presc[PR_CLK_LSB +: 2])
      CLK_DIV1: presTick = 1'b1;
      CLK_DIV4: presTick = (q.div[1:0] == DIV4_LAST[1:0]);
      CLK_DIV16: presTick = (q.div == DIV16_LAST);
      CLK_EVENT: presTick = edgeFirst;
      default: presTick = 1'b0;
    endcase
    countTick = running & presTick;

    // ========================================================================
    // APB decode
    // ========================================================================
    setup = apbReq.psel & ~apbReq.penable;
    commit = apbReq.psel & apbReq.penable & q.rsp.pready;
    doWrite = commit & apbReq.pwrite;
    fullWord16 = (apbReq.pstrb[1:0] == 2'b11);
    oneshotMode = q.outCtl[OC_ONESHOT_MODE];
    oneshotTrig = doWrite && (apbReq.paddr == ADDR_OUTCTL) && apbReq.pstrb[0]
                  && apbReq.pwdata[OC_ONESHOT_TRIG] && oneshotMode;

    // ========================================================================
    // Counter and compare
    // ========================================================================
    // The comparison happens only on a count, so a match-clear period is
    // the compare value plus one count clock.
    matchFirst = countTick & ~q.ccCtl[CC_MODE_FIRST] & (q.count == q.ccFirst);
    matchSecond = countTick & ~q.ccCtl[CC_MODE_SECOND] & (q.count == q.ccSecond);
    clearCount = matchFirst & (opMode == OPM_CLR_MATCH);
    wrapNow = countTick & ~clearCount & (q.count == COUNT_MAX);
    d.irqFirst = matchFirst;
    d.irqSecond = matchSecond;

    if (!running)
    begin
      d.count = RST_COUNT;
    end
    else if ((opMode == OPM_CLR_EDGE) && edgeFirst)
    begin
      d.count = RST_COUNT;
    end
    else if (oneshotTrig)
    begin
      d.count = RST_COUNT;
    end
    else if (clearCount)
    begin
      d.count = RST_COUNT;
    end
    else if (countTick)
    begin
      d.count = q.count + 16'h0001;
    end

    // ========================================================================
    // Output control
    // ========================================================================
    // Square wave: toggle on first match only. Pulse generation: toggle on
    // both matches, so the second value sets the width and the first the
    // cycle. One-shot: toggles act only while the single pulse runs.
    pulseActive = ~oneshotMode | (q.oneshot == TEC_OS_RUN);
    if (pulseActive && q.outCtl[OC_ENABLE])
    begin
      d.outLevel = q.outLevel ^ (matchFirst & q.outCtl[OC_INV_FIRST])
                   ^ (matchSecond & q.outCtl[OC_INV_SECOND]);
    end
    if (!q.outCtl[OC_ENABLE])
    begin
      d.outLevel = 1'b0;
    end
    d.outEnable = q.outCtl[OC_ENABLE];

    unique case (q.oneshot)
      TEC_OS_IDLE:
      begin
        if (oneshotTrig && running)
        begin
          d.oneshot = TEC_OS_RUN;
          d.outLevel = 1'b0;
        end
      end
      TEC_OS_RUN:
      begin
        if (!oneshotMode || !running || matchFirst)
        begin
          d.oneshot = TEC_OS_IDLE;
        end
      end
      default: d.oneshot = TEC_OS_IDLE;
    endcase

    // ========================================================================
    // Register writes
    // ========================================================================
    d.outCtl[OC_ONESHOT_TRIG] = 1'b0;
    if (doWrite)
    begin
      unique case (apbReq.paddr)
        ADDR_CCFIRST:
        begin
          if (fullWord16)
          begin
            d.ccFirst = apbReq.pwdata[15:0];
          end
        end
        ADDR_CCSECOND:
        begin
          if (fullWord16)
          begin
            d.ccSecond = apbReq.pwdata[15:0];
          end
        end
        ADDR_MODECTL:
        begin
          if (apbReq.pstrb[0])
          begin
            d.modeCtl[MC_SEL_HI:MC_SEL_LO] = apbReq.pwdata[MC_SEL_HI:MC_SEL_LO];
            d.modeCtl[1] = apbReq.pwdata[1];
            d.modeCtl[MC_OVF] = q.modeCtl[MC_OVF] & apbReq.pwdata[MC_OVF];
          end
        end
        ADDR_CCCTL:
        begin
          if (apbReq.pstrb[0])
          begin
            d.ccCtl = {5'b00000, apbReq.pwdata[2:0]};
          end
        end
        ADDR_PRESC:
        begin
          if (apbReq.pstrb[0])
          begin
            d.presc = {apbReq.pwdata[7:4], 2'b00, apbReq.pwdata[1:0]};
          end
        end
        ADDR_OUTCTL:
        begin
          if (apbReq.pstrb[0])
          begin
            d.outCtl = {1'b0, 1'b0, 1'b0, apbReq.pwdata[4], 1'b0,
                        apbReq.pwdata[2:0]};
          end
        end
        default:
        begin
          d.outCtl[OC_ONESHOT_TRIG] = 1'b0;
        end
      endcase
    end

    // A wrap sets the overflow flag even if software clears it this cycle.
    if (wrapNow)
    begin
      d.modeCtl[MC_OVF] = 1'b1;
    end

    // ========================================================================
    // Captures
    // ========================================================================
    // A capture overrides a software write that lands in the same cycle.
    if (q.ccCtl[CC_MODE_FIRST] && running)
    begin
      if (q.ccCtl[CC_SOURCE] ? capTrigFirst : capTrigSecond)
      begin
        d.ccFirst = q.count;
      end
    end
    // Only the first pin's valid edge captures here, never a counter read.
    if (q.ccCtl[CC_MODE_SECOND] && running && edgeFirst)
    begin
      d.ccSecond = q.count;
    end

    // ========================================================================
    // APB response
    // ========================================================================
    // Zero wait states: pready is high in the first access cycle. The read
    // data is a snapshot taken at the setup edge, so the counter never has
    // to stop and no count is dropped.
    d.rsp.pready = setup;
    if (setup)
    begin
      d.rsp.prdata = 32'h00000000;
      d.rsp.pslverr = 1'b0;
      unique case (apbReq.paddr)
        ADDR_COUNT:
        begin
          d.rsp.prdata = widen16(q.count);
          d.rsp.pslverr = apbReq.pwrite;
        end
        ADDR_CCFIRST:
        begin
          d.rsp.prdata = widen16(q.ccFirst);
          d.rsp.pslverr = apbReq.pwrite & ~fullWord16;
        end
        ADDR_CCSECOND:
        begin
          d.rsp.prdata = widen16(q.ccSecond);
          d.rsp.pslverr = apbReq.pwrite & ~fullWord16;
        end
        ADDR_MODECTL: d.rsp.prdata = widen8(q.modeCtl);
        ADDR_CCCTL: d.rsp.prdata = widen8(q.ccCtl);
        ADDR_PRESC: d.rsp.prdata = widen8(q.presc);
        ADDR_OUTCTL: d.rsp.prdata = widen8(q.outCtl);
        default: d.rsp.pslverr = 1'b1;
      endcase
    end
    else if (commit)
    begin
      d.rsp.pslverr = q.rsp.pslverr;
    end
    else
    begin
      d.rsp.prdata = 32'h00000000;
      d.rsp.pslverr = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      q.rsp <= '0;
      q.syncFirst <= 3'b000;
      q.syncSecond <= 3'b000;
      q.fltFirst <= 1'b0;
      q.fltSecond <= 1'b0;
      q.div <= 4'h0;
      q.count <= RST_COUNT;
      q.ccFirst <= RST_CC;
      q.ccSecond <= RST_CC;
      q.modeCtl <= RST_CTL;
      q.ccCtl <= RST_CTL;
      q.presc <= RST_CTL;
      q.outCtl <= RST_CTL;
      q.oneshot <= TEC_OS_IDLE;
      q.outLevel <= 1'b0;
      q.outEnable <= 1'b0;
      q.irqFirst <= 1'b0;
      q.irqSecond <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  assign apbRsp = q.rsp;
  assign timerOutputPin = q.outLevel;
  assign timerOutputEnable = q.outEnable;
  assign compareFirstIrq = q.irqFirst;
  assign compareSecondIrq = q.irqSecond;

endmodule
